// file: include/stma_pkg.sv
package stma_pkg;
    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    localparam int NCH = 5;
    localparam logic [2:0] CH_TEMP = 3'h4; // last channel of the scan
    // ------------------------------------------------------------
    // command codes (register pointer values)
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_CFG = 8'h00;
    localparam logic [7:0] CMD_STAT = 8'h01;
    localparam logic [7:0] CMD_MASK = 8'h02;
    localparam logic [7:0] CMD_ADDR = 8'h03;
    localparam logic [7:0] CMD_RES = 8'h10; // plus channel
    localparam logic [7:0] CMD_HI = 8'h20; // plus channel
    localparam logic [7:0] CMD_LO = 8'h30; // plus channel
    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int CFG_RUN = 0;
    localparam int CFG_ALERT = 1;
    localparam int CFG_MODE = 2; // two bits
    localparam logic [7:0] CFG_RST = 8'h03;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] VOLT_HI_RST = 8'hFF;
    localparam logic [7:0] TEMP_HI_RST = 8'h7F;
    localparam logic [7:0] LO_RST = 8'h00;
    localparam logic [4:0] ADDR_BASE = 5'h05; // arbitrary upper address bits
    localparam logic [6:0] ARA_ADDR = 7'h0C; // smbus alert response address
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TM_DEFAULT = 2'b00,
        TM_ONESHOT = 2'b01,
        TM_COMPARE = 2'b10
    } stma_tmode_e;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_ACK = 3'b010,
        ST_TX = 3'b011,
        ST_MACK = 3'b100
    } stma_state_e;
    typedef struct packed {
        logic [2:0] chan;
        logic [7:0] code;
        logic over;
        logic under;
    } stma_res_s;
    typedef struct packed {
        stma_state_e state;
        logic [2:0] bitc;
        logic [1:0] byte_no;
        logic done;
        logic ack;
        logic rw;
        logic ara;
        logic [7:0] ptr;
        logic [7:0] sh;
        logic [7:0] tx;
        logic [3:0] eq; // strap matches: sda, scl, high, low
        logic oe;
        logic wr;
        logic clr;
    } stma_slv_s;
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] mask;
        logic [NCH-1:0] status;
        logic [6:0] addr;
        logic ovr;
        logic armed;
        logic [NCH-1:0][7:0] res;
        logic [NCH-1:0][7:0] hi;
        logic [NCH-1:0][7:0] lo;
        logic alert;
    } stma_regs_s;
    localparam stma_regs_s REGS_RST = '{cfg: CFG_RST, mask: MASK_RST, status: '0,
        addr: '0, ovr: 1'h0, armed: 1'h1, res: '0,
        hi: {TEMP_HI_RST, {4{VOLT_HI_RST}}}, lo: {NCH{LO_RST}}, alert: 1'h0};
endpackage

// file: src/stma_scan.sv
`timescale 1ns/10ps
module stma_scan
    import stma_pkg::*;
(
    input wire logic core_clk_i, // core clock
    input wire logic reset_i, // synchronous reset
    input wire logic run_i, // scanning enabled
    input wire logic conv_valid_i, // converter result strobe
    input wire logic [7:0] conv_code_i, // converter result code
    input wire logic [7:0] hi_i, // upper limit of current channel
    input wire logic [7:0] lo_i, // lower limit of current channel
    output logic conv_req_o, // conversion request level
    output logic [2:0] conv_chan_o, // channel being converted
    output logic res_valid_o, // result strobe
    output stma_res_s res_o // stored result and compare flags
);
    logic busy;
    logic next_busy;
    logic [2:0] chan;
    logic [2:0] next_chan;
    logic next_valid;
    stma_res_s next_res;
    logic signed [8:0] code_x;
    logic signed [8:0] hi_x;
    logic signed [8:0] lo_x;

    // ------------------------------------------------------------
    // channel sequencer and limit compare
    // ------------------------------------------------------------
    always_comb begin
        next_busy = busy;
        next_chan = chan;
        next_valid = 1'h0;
        next_res = res_o;
        // temperature is signed, voltages are straight binary
        if (chan == CH_TEMP) begin
            code_x = {conv_code_i[7], conv_code_i};
            hi_x = {hi_i[7], hi_i};
            lo_x = {lo_i[7], lo_i};
        end else begin
            code_x = {1'h0, conv_code_i};
            hi_x = {1'h0, hi_i};
            lo_x = {1'h0, lo_i};
        end
        if (!busy) begin
            next_busy = run_i;
        end else if (conv_valid_i) begin
            next_valid = 1'h1;
            next_res = '{chan: chan, code: conv_code_i, over: code_x > hi_x,
                under: code_x < lo_x};
            next_busy = run_i;
            next_chan = (chan == CH_TEMP) ? 3'h0 : chan + 3'h1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            busy <= 1'h0;
            chan <= 3'h0;
            res_valid_o <= 1'h0;
            res_o <= '0;
        end else begin
            busy <= next_busy;
            chan <= next_chan;
            res_valid_o <= next_valid;
            res_o <= next_res;
        end
    end

    assign conv_req_o = busy;
    assign conv_chan_o = chan;

    res_take_a: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        busy && conv_valid_i |=> res_valid_o && res_o.code == $past(conv_code_i)
        && res_o.chan == $past(chan)) else $error("result not taken from converter");
    chan_step_a: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        busy && conv_valid_i && chan != CH_TEMP |=> chan == $past(chan) + 3'h1)
        else $error("scan did not step to next channel");
endmodule

// file: src/stma_top.sv
`timescale 1ns/10ps
// Notes on behaviour
// - each voltage and temperature conversion yields one 8-bit code.
// - the scan steps through all channels, stores each code and compares it with its limits.
// - a temperature above its limit or a voltage outside its window latches the alert.
// - temperature alarms follow a default, a one-shot or a comparator mode.
// - reading the status register clears alarms, except a comparator-mode temperature alarm.
// - a set mask bit keeps its source off the alert output.
// - with config bit 1 at zero the alert output stays off.
// - the slave also answers the alert response address while it alerts.
// - write-byte, read-byte, send-byte and receive-byte transfers reach the registers.
// - voltage codes are stored as converted, nominal input reading 192.
// - temperature codes are two's complement with one degree per count.
// - the strap pin tied low, high, to data or to clock picks one of four addresses.
// - the low two address bits are sensed from the strap in every transfer.
// - a written slave address replaces the strapped one until the next reset.
module stma_top
    import stma_pkg::*;
(
    input wire logic core_clk_i, // core clock, 200 MHz
    input wire logic reset_i, // synchronous reset, power-on
    input wire logic scl_i, // serial clock pin
    input wire logic sda_i, // serial data pin level
    output logic sda_o, // serial data drive value
    output logic sda_oe_o, // serial data pull low
    input wire logic strap_i, // address strap pin level
    output logic alert_o, // alert drive value
    output logic alert_oe_o, // alert pull low
    output logic conv_req_o, // conversion request
    output logic [2:0] conv_chan_o, // channel to convert
    input wire logic conv_valid_i, // conversion done strobe
    input wire logic [7:0] conv_code_i // conversion result
);
    logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d, strap_m, strap_s;
    logic scl_rise, scl_fall, start, stop;
    stma_slv_s s, n;
    stma_regs_s r, nr;
    logic [7:0] rx_byte, rd_byte, tx_load;
    logic [6:0] my_addr;
    logic [1:0] strap_code, tmode;
    logic res_v;
    stma_res_s res;

    // ------------------------------------------------------------
    // pin synchronisers and line events
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            {scl_m, scl_s, scl_d, sda_m, sda_s, sda_d} <= 6'h3F;
            {strap_m, strap_s} <= 2'h0;
        end else begin
            {scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
            {sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
            {strap_m, strap_s} <= {strap_i, strap_m};
        end
    end
    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign start = scl_s && scl_d && sda_d && !sda_s;
    assign stop = scl_s && scl_d && !sda_d && sda_s;

    // ------------------------------------------------------------
    // slave address
    // ------------------------------------------------------------
    // a constant strap wins over a match with a toggling line
    assign strap_code = s.eq[0] ? 2'h0 : s.eq[1] ? 2'h1 : s.eq[2] ? 2'h3 : 2'h2;
    assign my_addr = r.ovr ? r.addr : {ADDR_BASE, strap_code};
    assign tmode = r.cfg[CFG_MODE +: 2];

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb begin
        rd_byte = 8'h00;
        if (s.ptr == CMD_CFG) rd_byte = r.cfg;
        if (s.ptr == CMD_STAT) rd_byte = {3'h0, r.status};
        if (s.ptr == CMD_MASK) rd_byte = r.mask;
        if (s.ptr == CMD_ADDR) rd_byte = {1'h0, my_addr};
        for (int i = 0; i < NCH; i++) begin
            if (s.ptr == CMD_RES + 8'(i)) rd_byte = r.res[i];
            if (s.ptr == CMD_HI + 8'(i)) rd_byte = r.hi[i];
            if (s.ptr == CMD_LO + 8'(i)) rd_byte = r.lo[i];
        end
    end
    assign tx_load = s.ara ? {my_addr, 1'h0} : rd_byte;

    // ------------------------------------------------------------
    // serial slave
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        n.wr = 1'h0;
        n.clr = 1'h0;
        rx_byte = {s.sh[6:0], sda_s};
        if (start) begin
            n.state = ST_RX;
            n.bitc = 3'h0;
            n.byte_no = 2'h0;
            n.done = 1'h0;
            n.ara = 1'h0;
            n.eq = 4'hF;
        end else if (stop) begin
            n.state = ST_IDLE;
        end else begin
            unique case (s.state)
                ST_IDLE: begin
                end
                ST_RX: begin
                    if (s.byte_no == 2'h0) begin
                        n.eq = s.eq & {strap_s == sda_s, strap_s == scl_s, strap_s, !strap_s};
                    end
                    if (scl_rise) begin
                        n.sh = rx_byte;
                        n.bitc = s.bitc + 3'h1;
                        if (s.bitc == 3'h7) begin
                            n.done = 1'h1;
                            n.ack = 1'h1;
                            if (s.byte_no == 2'h0) begin
                                n.rw = rx_byte[0];
                                n.ara = rx_byte[7:1] == ARA_ADDR && rx_byte[0] && alert_oe_o;
                                n.ack = rx_byte[7:1] == my_addr || n.ara;
                            end else if (s.byte_no == 2'h1) begin
                                n.ptr = rx_byte;
                            end else begin
                                n.wr = 1'h1;
                            end
                            if (s.byte_no != 2'h2) n.byte_no = s.byte_no + 2'h1;
                        end
                    end
                    if (scl_fall && s.done) begin
                        n.done = 1'h0;
                        n.state = s.ack ? ST_ACK : ST_IDLE;
                    end
                end
                ST_ACK, ST_MACK: begin
                    if (s.state == ST_MACK && scl_rise && sda_s) begin
                        n.state = ST_IDLE;
                    end else if (scl_fall) begin
                        n.bitc = 3'h0;
                        if (s.rw) begin
                            n.state = ST_TX;
                            n.tx = tx_load;
                            n.clr = s.ara || s.ptr == CMD_STAT;
                        end else begin
                            n.state = ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        n.bitc = s.bitc + 3'h1;
                        n.tx = {s.tx[6:0], 1'h0};
                        if (s.bitc == 3'h7) n.state = ST_MACK;
                    end
                end
                default: n.state = ST_IDLE;
            endcase
        end
        n.oe = n.state == ST_ACK || (n.state == ST_TX && !n.tx[7]);
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) s <= '0;
        else s <= n;
    end

    // ------------------------------------------------------------
    // registers and alarms
    // ------------------------------------------------------------
    always_comb begin
        nr = r;
        if (s.wr) begin
            if (s.ptr == CMD_CFG) nr.cfg = s.sh;
            if (s.ptr == CMD_MASK) nr.mask = s.sh;
            if (s.ptr == CMD_ADDR) begin
                nr.addr = s.sh[6:0];
                nr.ovr = 1'h1;
            end
            for (int i = 0; i < NCH; i++) begin
                if (s.ptr == CMD_HI + 8'(i)) nr.hi[i] = s.sh;
                if (s.ptr == CMD_LO + 8'(i)) nr.lo[i] = s.sh;
            end
        end
        // clear first so that a result in the same cycle still sets
        if (s.clr) begin
            nr.status = r.status & (tmode == TM_COMPARE ? 5'h10 : 5'h00);
        end
        if (res_v) begin
            nr.res[res.chan] = res.code;
            if (res.chan != CH_TEMP) begin
                if (res.over || res.under) nr.status[res.chan] = 1'h1;
            end else if (tmode == TM_COMPARE) begin
                nr.status[CH_TEMP] = res.over;
            end else if (tmode == TM_ONESHOT) begin
                if (res.over && r.armed) nr.status[CH_TEMP] = 1'h1;
                nr.armed = !res.over;
            end else if (res.over) begin
                nr.status[CH_TEMP] = 1'h1;
            end
        end
        nr.alert = r.cfg[CFG_ALERT] && |(r.status & ~r.mask[NCH-1:0]);
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) r <= REGS_RST;
        else r <= nr;
    end

    stma_scan u_scan (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .run_i(r.cfg[CFG_RUN]),
        .conv_valid_i(conv_valid_i),
        .conv_code_i(conv_code_i),
        .hi_i(r.hi[conv_chan_o]),
        .lo_i(r.lo[conv_chan_o]),
        .conv_req_o(conv_req_o),
        .conv_chan_o(conv_chan_o),
        .res_valid_o(res_v),
        .res_o(res)
    );

    assign sda_o = 1'h0;
    assign sda_oe_o = s.oe;
    assign alert_o = 1'h0;
    assign alert_oe_o = r.alert;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);

    alert_cfg_a: assert property (
        !r.cfg[CFG_ALERT] |=> !alert_oe_o) else $error("alert not held off by config");
    alert_mask_a: assert property (
        (r.status & ~r.mask[NCH-1:0]) == 5'h00 |=> !alert_oe_o) else $error("masked alert");
    volt_set_a: assert property (
        res_v && res.chan != CH_TEMP && (res.over || res.under) |=> r.status[$past(res.chan)]
        ##1 alert_oe_o || !r.cfg[CFG_ALERT] || r.mask[$past(res.chan, 2)] || s.clr
        || $past(s.clr)) else $error("voltage alarm not latched");
    read_clear_a: assert property (
        s.clr && !res_v && tmode != TM_COMPARE |=> r.status == 5'h00)
        else $error("status read did not clear");
    comp_hold_a: assert property (
        s.clr && !res_v && tmode == TM_COMPARE && r.status[CH_TEMP] |=> r.status[CH_TEMP])
        else $error("comparator alarm cleared by read");
    comp_release_a: assert property (
        res_v && res.chan == CH_TEMP && !res.over && tmode == TM_COMPARE
        |=> !r.status[CH_TEMP]) else $error("comparator alarm not released");
    one_shot_a: assert property (
        res_v && res.chan == CH_TEMP && res.over && !r.armed && tmode == TM_ONESHOT && !s.clr
        |=> $stable(r.status[CH_TEMP])) else $error("one-shot alarm fired twice");
    store_a: assert property (
        res_v |=> r.res[$past(res.chan)] == $past(res.code)) else $error("result not stored");
    addr_write_a: assert property (
        s.wr && s.ptr == CMD_ADDR |=> r.ovr && my_addr == $past(s.sh[6:0]))
        else $error("written address not in effect");
    ara_ack_a: assert property (
        s.state == ST_RX && scl_rise && s.bitc == 3'h7 && s.byte_no == 2'h0 && !start && !stop
        && rx_byte == {ARA_ADDR, 1'h1} && alert_oe_o |=> s.ack && s.ara)
        else $error("alert response address ignored");
    idle_release_a: assert property (
        s.state == ST_IDLE |-> !sda_oe_o) else $error("data line driven while idle");
endmodule

// file: tb/stma_host.sv
`timescale 1ns/10ps
module stma_host (
    output logic scl_o, // serial clock line
    output logic sda_low_o, // high pulls the data wire low
    input wire logic sda_i // data wire level
);
    // ------------------------------------------------------------
    // bus cycles, 64 ns per bit
    // ------------------------------------------------------------
    localparam time Q = 16;
    initial begin
        scl_o = 1'h1;
        sda_low_o = 1'h0;
    end
    // data is released while the clock is low, so this also serves as a repeated start
    task automatic start();
        sda_low_o = 1'h0;
        #Q scl_o = 1'h1;
        #Q sda_low_o = 1'h1;
        #Q scl_o = 1'h0;
        #Q;
    endtask
    task automatic stop();
        sda_low_o = 1'h1;
        #Q scl_o = 1'h1;
        #Q sda_low_o = 1'h0;
        #Q;
    endtask
    // sampled just before the falling clock, after the slave has settled its bit
    task automatic bit_io(input logic b, output logic got);
        sda_low_o = !b;
        #Q scl_o = 1'h1;
        #(2 * Q) got = sda_i;
        scl_o = 1'h0;
        #Q;
    endtask
    // msb first; mack high acknowledges a read byte, ack returned active high
    task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
        output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], g);
            rx[i] = g;
        end
        bit_io(!mack, g);
        ack = !g;
    endtask
endmodule

// file: tb/stma_tb_top.sv
`timescale 1ns/10ps
module stma_tb_top import stma_pkg::*;;
    logic core_clk_i;
    logic reset_i = 1'h1;
    logic conv_valid_i = 1'h0;
    logic [7:0] conv_code_i = 8'h00;
    logic strap_i, scl, host_low, sda_w, sda_o, sda_oe_o, alert_o, alert_oe_o, conv_req_o;
    logic [2:0] conv_chan_o;
    logic [1:0] sel = 2'h0;
    logic [6:0] dev = {ADDR_BASE, 2'h0};
    int miscompares = 0;
    int comparisons = 0;
    // open-drain data wire with pull-up; strap tied low, high, to data or to clock
    assign sda_w = !host_low && !(sda_oe_o && !sda_o);
    assign strap_i = sel[1] ? (sel[0] ? scl : sda_w) : sel[0];
    stma_top i_stma_top (.core_clk_i(core_clk_i), .reset_i(reset_i), .scl_i(scl),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .strap_i(strap_i),
        .alert_o(alert_o), .alert_oe_o(alert_oe_o), .conv_req_o(conv_req_o),
        .conv_chan_o(conv_chan_o), .conv_valid_i(conv_valid_i), .conv_code_i(conv_code_i));
    stma_host i_stma_host (.scl_o(scl), .sda_low_o(host_low), .sda_i(sda_w));
    initial begin
        core_clk_i = 1'h0;
        forever #2.5 core_clk_i = !core_clk_i;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic conclude();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // checks both the enable and that the alert wire is really pulled low
    task automatic alert_is(input logic e);
        chk({6'h00, alert_oe_o, alert_oe_o && !alert_o}, {6'h00, e, e});
    endtask
    task automatic do_reset();
        reset_i = 1'h1;
        repeat (20) @(negedge core_clk_i);
        reset_i = 1'h0;
        repeat (4) @(negedge core_clk_i);
    endtask
    // write byte, or send byte when has_data is low
    task automatic wr(input logic [7:0] cmd, input logic [7:0] v, input logic has_data);
        logic [7:0] r;
        logic a;
        i_stma_host.start();
        i_stma_host.xfer({dev, 1'h0}, 1'h0, r, a);
        chk({7'h00, a}, 8'h01);
        i_stma_host.xfer(cmd, 1'h0, r, a);
        chk({7'h00, a}, 8'h01);
        if (has_data) begin
            i_stma_host.xfer(v, 1'h0, r, a);
            chk({7'h00, a}, 8'h01);
        end
        i_stma_host.stop();
    endtask
    // receive byte; a refused address just ends the transfer
    task automatic rcv(input logic [6:0] ad, output logic [7:0] d, output logic a);
        logic [7:0] r;
        logic x;
        d = 8'h00;
        i_stma_host.start();
        i_stma_host.xfer({ad, 1'h1}, 1'h0, r, a);
        if (a) begin
            i_stma_host.xfer(8'hFF, 1'h0, d, x);
        end
        i_stma_host.stop();
    endtask
    task automatic rd(input logic [7:0] cmd, input logic [7:0] e);
        logic [7:0] r;
        logic a;
        i_stma_host.start();
        i_stma_host.xfer({dev, 1'h0}, 1'h0, r, a);
        chk({7'h00, a}, 8'h01);
        i_stma_host.xfer(cmd, 1'h0, r, a);
        rcv(dev, r, a);
        chk(r, e);
    endtask
    // one code per channel, valids back to back
    task automatic scan(input logic [4:0][7:0] v);
        int n;
        for (int k = 0; k < NCH; k++) begin
            n = 0;
            while (!(conv_req_o === 1'h1 && conv_chan_o === 3'(k)) && n < 40) begin
                @(negedge core_clk_i);
                n++;
            end
            chk({5'h00, conv_chan_o}, 8'(k));
            if (n == 40) begin
                miscompares++;
                conclude();
            end
            conv_valid_i = 1'h1;
            conv_code_i = v[k];
            @(negedge core_clk_i);
        end
        conv_valid_i = 1'h0;
        repeat (5) @(negedge core_clk_i);
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] d;
        logic a;
        logic [4:0][7:0] v;
        do_reset();
        alert_is(1'h0);
        chk({7'h00, conv_req_o}, 8'h01);
        rd(CMD_CFG, CFG_RST);
        rd(CMD_HI, VOLT_HI_RST);
        rd(CMD_HI + 8'h04, TEMP_HI_RST);
        rd(CMD_LO + 8'h02, LO_RST);
        v = {8'hE7, 8'hC0, 8'hC0, 8'h40, 8'hC0};
        scan(v);
        for (int k = 0; k < NCH; k++) begin
            rd(CMD_RES + 8'(k), v[k]);
        end
        alert_is(1'h0);
        $display("test reset and results done");
        wr(CMD_HI + 8'h01, 8'hC0, 1'h1);
        wr(CMD_LO + 8'h02, 8'h10, 1'h1);
        scan({8'h00, 8'h80, 8'h10, 8'hC0, 8'h80});
        alert_is(1'h0);
        scan({8'h00, 8'h80, 8'h0F, 8'hC1, 8'h80});
        alert_is(1'h1);
        rd(CMD_STAT, 8'h06);
        alert_is(1'h0);
        wr(CMD_MASK, 8'h02, 1'h1);
        scan({8'h00, 8'h80, 8'h80, 8'hC1, 8'h80});
        alert_is(1'h0);
        rd(CMD_STAT, 8'h02);
        wr(CMD_MASK, 8'h00, 1'h1);
        wr(CMD_CFG, 8'h01, 1'h1);
        scan({8'h00, 8'h80, 8'h80, 8'hC1, 8'h80});
        alert_is(1'h0);
        wr(CMD_CFG, 8'h03, 1'h1);
        alert_is(1'h1);
        rcv(ARA_ADDR, d, a);
        chk({7'h00, a}, 8'h01);
        chk(d, {dev, 1'h0});
        alert_is(1'h0);
        rcv(ARA_ADDR, d, a);
        chk({7'h00, a}, 8'h00);
        $display("test voltage alarms done");
        wr(CMD_HI + 8'h04, 8'h19, 1'h1);
        // mode code 3 is spare and must behave as the default mode
        for (int m = 0; m < 4; m++) begin
            wr(CMD_CFG, {4'h0, 2'(m), 2'h3}, 1'h1);
            scan({8'h1A, 32'h80808080});
            alert_is(1'h1);
            rd(CMD_STAT, 8'h10);
            alert_is(m == 2);
            scan({8'h1A, 32'h80808080});
            alert_is(m != 1);
            rd(CMD_STAT, (m == 1) ? 8'h00 : 8'h10);
            scan({8'hE7, 32'h80808080});
            alert_is(1'h0);
            scan({8'h1A, 32'h80808080});
            alert_is(1'h1);
            scan({8'hE7, 32'h80808080});
            rd(CMD_STAT, (m == 2) ? 8'h00 : 8'h10);
        end
        $display("test temperature modes done");
        for (int s = 0; s < 4; s++) begin
            sel = 2'(s);
            dev = {ADDR_BASE, 2'(s)};
            rd(CMD_CFG, 8'h0F);
            rcv({ADDR_BASE, 2'(s) ^ 2'h1}, d, a);
            chk({7'h00, a}, 8'h00);
        end
        wr(CMD_ADDR, 8'h5A, 1'h1);
        rcv(dev, d, a);
        chk({7'h00, a}, 8'h00);
        dev = 7'h5A;
        wr(CMD_MASK, 8'h15, 1'h1);
        wr(CMD_CFG, 8'h00, 1'h0);
        rcv(dev, d, a);
        chk(d, 8'h0F);
        wr(CMD_MASK, 8'h00, 1'h0);
        rcv(dev, d, a);
        chk(d, 8'h15);
        do_reset();
        rcv(dev, d, a);
        chk({7'h00, a}, 8'h00);
        dev = {ADDR_BASE, 2'h3};
        rd(CMD_MASK, MASK_RST);
        $display("test addressing done");
        conclude();
    end
endmodule
